// ### shared/pll_cfg_pkg.sv
// constants, field positions and carriers for the pll configuration registers
package pll_cfg_pkg;

  localparam int WORD_W = 32;
  localparam int CTRL_W = 4;

  // register select codes carried in the low four bits of every word
  localparam logic [3:0] CTRL_INTEGER = 4'h0;
  localparam logic [3:0] CTRL_AUX_MOD = 4'h2;
  localparam logic [3:0] CTRL_AUX_FRAC = 4'h3;
  localparam logic [3:0] CTRL_REF_PWR = 4'h4;
  localparam logic [3:0] CTRL_BLEED = 4'h5;
  localparam logic [3:0] CTRL_REG_SIX = 4'h6;

  // auxiliary modulus and fraction field
  localparam int AUX_W = 14;
  localparam int AUX_MSB = 17;
  localparam int AUX_LSB = 4;

  // reference and power control fields
  localparam int DITHER2_BIT = 30;
  localparam int MUX_MSB = 29;
  localparam int MUX_LSB = 27;
  localparam int DOUBLER_BIT = 26;
  localparam int HALVE_BIT = 25;
  localparam int RATIO_W = 10;
  localparam int RATIO_MSB = 24;
  localparam int RATIO_LSB = 15;
  localparam int DBUF_BIT = 14;
  localparam int CP_MSB = 13;
  localparam int CP_LSB = 10;
  localparam int MUX_LEVEL_BIT = 8;
  localparam int POLARITY_BIT = 7;
  localparam int PWR_DOWN_BIT = 6;
  localparam int CP_TRI_BIT = 5;
  localparam int CNT_RESET_BIT = 4;

  // bleed and antibacklash fields
  localparam int BLEED_DLY_MSB = 27;
  localparam int BLEED_DLY_LSB = 26;
  localparam int PULSED_BIT = 25;
  localparam int ABP_BIT = 23;
  localparam logic [2:0] ABP_NARROW_CODE = 3'h4;

  // register six output divider bits
  localparam int RFDIV_MSB = 23;
  localparam int RFDIV_LSB = 21;

  // reset values
  localparam logic [13:0] AUX_RST = 14'h0000;
  localparam logic [9:0] RATIO_RST = 10'h001;
  localparam logic [2:0] RFDIV_RST = 3'h0;

  typedef struct packed {
    logic       dither2En;
    logic [2:0] muxSelect;
    logic       doublerEn;
    logic       halvingEn;
    logic [9:0] refRatio;
    logic       dbufEn;
    logic [3:0] cpCurrent;
    logic       muxLevelDigital;
    logic       polarityPositive;
    logic       powerDown;
    logic       cpTristate;
    logic       counterReset;
  } refPwrCfg_s;

  typedef struct packed {
    logic       pulsedEn;
    logic [1:0] bleedDelay;
    logic       abpNarrow;
  } bleedCfg_s;

endpackage

// ### verilog/serial_word_capture.sv
// three-wire serial shift register with latch strobe
`timescale 1ns/10ps
module serial_word_capture
  import pll_cfg_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              serClk,
  input  wire logic              serData,
  input  wire logic              serLatch,
  output logic [WORD_W-1:0]      word,
  output logic                   wordValid
);

  logic [WORD_W-1:0] shift_q;      // bits as they arrive, msb first
  logic              serClkPrev_q; // last serial clock level
  logic              latchPrev_q;  // last latch level

  wire clkRise = serClk & ~serClkPrev_q;
  wire latchRise = serLatch & ~latchPrev_q;

  // edge history of the pins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serClkPrev_q <= 1'b0;
      latchPrev_q  <= 1'b0;
    end
    else
    begin
      serClkPrev_q <= serClk;
      latchPrev_q  <= serLatch;
    end
  end

  // shift in on serial clock rise; word leaves only on latch rise
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_q   <= '0;
      word      <= '0;
      wordValid <= 1'b0;
    end
    else
    begin
      if (clkRise)
        shift_q <= {shift_q[WORD_W-2:0], serData};
      wordValid <= latchRise;
      if (latchRise)
        word <= shift_q;
    end
  end

endmodule

// ### verilog/reference_divider.sv
// reference edge selection, 10-bit ratio divider and halving toggle
`timescale 1ns/10ps
module reference_divider
  import pll_cfg_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               reference_input,
  input  wire logic               doublerEn,
  input  wire logic               halvingEn,
  input  wire logic [RATIO_W-1:0] refRatio,
  input  wire logic               hold,
  output logic                    pfdRefPulse
);

  logic               refPrev_q;  // last reference level
  logic [RATIO_W-1:0] count_q;    // active edges seen this period
  logic               toggle_q;   // halving flip-flop

  wire fallEdge = refPrev_q & ~reference_input;
  wire anyEdge = refPrev_q ^ reference_input;
  // doubler makes both edges count, otherwise only the falling one
  wire activeEdge = doublerEn ? anyEdge : fallEdge;
  // a ratio of zero is illegal; it behaves as one
  wire [RATIO_W-1:0] lastCount = (refRatio == '0) ? '0 : refRatio - 1'b1;
  wire divOut = activeEdge && (count_q == lastCount);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refPrev_q   <= 1'b0;
      count_q     <= '0;
      toggle_q    <= 1'b0;
      pfdRefPulse <= 1'b0;
    end
    else
    begin
      refPrev_q <= reference_input;
      if (hold)
      begin
        // counters sit in their load state
        count_q     <= '0;
        toggle_q    <= 1'b0;
        pfdRefPulse <= 1'b0;
      end
      else
      begin
        if (divOut)
          count_q <= '0;
        else if (activeEdge)
          count_q <= count_q + 1'b1;
        if (divOut)
          toggle_q <= ~toggle_q;
        pfdRefPulse <= divOut && (!halvingEn || toggle_q);
      end
    end
  end

endmodule

// ### verilog/pll_config_regs.sv
// configuration registers two to six of the fractional-n synthesizer
//
// What this block does
// - control codes 0 and 2..6 pick the target register
// - auxiliary modulus taken from bits 17..4
// - modulus shadowed until next integer write
// - bit 30 enables second stage dither
// - bits 29..27 choose multiplexed output source
// - bit 26 doubles reference, both edges active
// - bit 25 halves divider output by toggle
// - ten-bit reference ratio, host uses 1..1023
// - bit 14 shadows register six divider bits
// - bits 13..10 set charge pump current
// - bit 8 picks output high level
// - bit 7 sets phase detector polarity
// - bit 6 powers down, contents retained
// - power-down resets counters, tristates, keeps writes
// - bit 5 tristates the charge pump
// - bit 4 holds n and r counters
// - bleed bit 25 pulses, delay bits 27..26
// - bit 23 picks fixed narrow antibacklash
// - divider bits move on integer write if shadowing
// - register six bits 23..21 pick divider
`timescale 1ns/10ps
module pll_config_regs
  import pll_cfg_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         serClk,
  input  wire logic         serData,
  input  wire logic         serLatch,
  input  wire logic         reference_input,
  output logic [AUX_W-1:0]  auxModulus,
  output logic [AUX_W-1:0]  auxFraction,
  output refPwrCfg_s        refPwr,
  output bleedCfg_s         bleed,
  output logic [2:0]        abpWidthCode,
  output logic [2:0]        rfDividerSel,
  output logic              cpHighZ,
  output logic              countersHeld,
  output logic              lockDetectClear,
  output logic              rfBuffersOff,
  output logic              integerLoad,
  output logic              pfdRefPulse
);

  //////////////////////////////////////////////////////////////////////////
  // helpers

  // true when a freshly latched word carries the given select code
  function automatic logic selects(input logic [WORD_W-1:0] w,
                                   input logic              v,
                                   input logic [3:0]        code);
    selects = v && (w[CTRL_W-1:0] == code);
  endfunction

  // the 14-bit field shared by modulus and fraction words
  function automatic logic [AUX_W-1:0] auxField(
    input logic [WORD_W-1:0] w);
    auxField = w[AUX_MSB:AUX_LSB];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // serial word capture

  logic [WORD_W-1:0] word;       // last latched word
  logic              wordValid;  // one-cycle pulse per latch

  serial_word_capture u_capture (
    .clk       (clk),
    .rst_n     (rst_n),
    .serClk    (serClk),
    .serData   (serData),
    .serLatch  (serLatch),
    .word      (word),
    .wordValid (wordValid)
  );

  //////////////////////////////////////////////////////////////////////////
  // select decode

  wire hitInteger = selects(word, wordValid, CTRL_INTEGER);
  wire hitAuxMod = selects(word, wordValid, CTRL_AUX_MOD);
  wire hitAuxFrac = selects(word, wordValid, CTRL_AUX_FRAC);
  wire hitRefPwr = selects(word, wordValid, CTRL_REF_PWR);
  wire hitBleed = selects(word, wordValid, CTRL_BLEED);
  wire hitRegSix = selects(word, wordValid, CTRL_REG_SIX);

  //////////////////////////////////////////////////////////////////////////
  // field extraction from the latched word

  refPwrCfg_s refPwr_d;  // reference and power word, unpacked
  bleedCfg_s  bleed_d;   // bleed word, unpacked

  assign refPwr_d.dither2En = word[DITHER2_BIT];
  assign refPwr_d.muxSelect = word[MUX_MSB:MUX_LSB];
  assign refPwr_d.doublerEn = word[DOUBLER_BIT];
  assign refPwr_d.halvingEn = word[HALVE_BIT];
  assign refPwr_d.refRatio = word[RATIO_MSB:RATIO_LSB];
  assign refPwr_d.dbufEn = word[DBUF_BIT];
  assign refPwr_d.cpCurrent = word[CP_MSB:CP_LSB];
  assign refPwr_d.muxLevelDigital = word[MUX_LEVEL_BIT];
  assign refPwr_d.polarityPositive = word[POLARITY_BIT];
  assign refPwr_d.powerDown = word[PWR_DOWN_BIT];
  assign refPwr_d.cpTristate = word[CP_TRI_BIT];
  assign refPwr_d.counterReset = word[CNT_RESET_BIT];

  assign bleed_d.pulsedEn = word[PULSED_BIT];
  assign bleed_d.bleedDelay = word[BLEED_DLY_MSB:BLEED_DLY_LSB];
  assign bleed_d.abpNarrow = word[ABP_BIT];

  //////////////////////////////////////////////////////////////////////////
  // auxiliary modulus and fraction

  logic [AUX_W-1:0] auxModShadow_q;  // written modulus, not yet live

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      auxModShadow_q <= AUX_RST;
    else if (hitAuxMod)
      auxModShadow_q <= auxField(word);
  end

  // live only on integer write
  // a modulus and integer latched in the same word cannot happen, so the
  // shadow always holds the value software wrote before the integer word
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      auxModulus <= AUX_RST;
    else if (hitInteger)
      auxModulus <= auxModShadow_q;
  end

  // fraction is live at once; the host keeps it below the modulus
  // no range check here
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      auxFraction <= AUX_RST;
    else if (hitAuxFrac)
      auxFraction <= auxField(word);
  end

  //////////////////////////////////////////////////////////////////////////
  // reference, charge pump and power register

  // held through power-down
  // nothing here clears on power-down, so all settings survive it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refPwr          <= '0;
      refPwr.refRatio <= RATIO_RST;
    end
    else if (hitRefPwr)
      refPwr <= refPwr_d;
  end

  //////////////////////////////////////////////////////////////////////////
  // bleed and antibacklash register

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bleed <= '0;
    else if (hitBleed)
      bleed <= bleed_d;
  end

  // narrow width or delay code
  // the delay code sets the width even with pulsed bleed off
  wire [2:0] abpWidth_d = bleed.abpNarrow ? ABP_NARROW_CODE
                                          : {1'b0, bleed.bleedDelay};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      abpWidthCode <= '0;
    else
      abpWidthCode <= abpWidth_d;
  end

  //////////////////////////////////////////////////////////////////////////
  // register six output divider bits

  logic [2:0] rfDivShadow_q;  // divider bits waiting for integer write

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rfDivShadow_q <= RFDIV_RST;
    else if (hitRegSix)
      rfDivShadow_q <= word[RFDIV_MSB:RFDIV_LSB];
  end

  // transfer on integer write
  // with shadowing off the divider follows each register six word at once
  wire [2:0] rfDiv_d =
    (!refPwr.dbufEn && hitRegSix) ? word[RFDIV_MSB:RFDIV_LSB] :
    (refPwr.dbufEn && hitInteger) ? rfDivShadow_q :
                                    rfDividerSel;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rfDividerSel <= RFDIV_RST;
    else
      rfDividerSel <= rfDiv_d;
  end

  //////////////////////////////////////////////////////////////////////////
  // power-down effects on the analog core

  wire cpHighZ_d = refPwr.cpTristate | refPwr.powerDown;
  wire countersHeld_d = refPwr.counterReset | refPwr.powerDown;
  wire lockClear_d = refPwr.powerDown;
  wire rfOff_d = refPwr.powerDown;

  // registered so every core control leaves a flip-flop cleanly
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpHighZ         <= 1'b0;
      countersHeld    <= 1'b0;
      lockDetectClear <= 1'b0;
      rfBuffersOff    <= 1'b0;
      integerLoad     <= 1'b0;
    end
    else
    begin
      cpHighZ         <= cpHighZ_d;
      countersHeld    <= countersHeld_d;
      lockDetectClear <= lockClear_d;
      rfBuffersOff    <= rfOff_d;
      // tells the integer register outside that its word was latched
      // host writes the integer word last
      integerLoad     <= hitInteger;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // reference path to the phase detector

  // held by counter reset
  // the hold uses the registered level, so it lags the word by one cycle
  reference_divider u_refdiv (
    .clk         (clk),
    .rst_n       (rst_n),
    .reference_input       (reference_input),
    .doublerEn   (refPwr.doublerEn),
    .halvingEn   (refPwr.halvingEn),
    .refRatio    (refPwr.refRatio),
    .hold        (countersHeld),
    .pfdRefPulse (pfdRefPulse)
  );

endmodule

// ### tb/pll_config_regs_asserts.sv
// port checker for the pll configuration registers
`timescale 1ns/10ps
module pll_config_regs_asserts
  import pll_cfg_pkg::*;
(
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic             serClk,
  input wire logic             serData,
  input wire logic             serLatch,
  input wire logic             reference_input,
  input wire logic [AUX_W-1:0] auxModulus,
  input wire logic [AUX_W-1:0] auxFraction,
  input wire refPwrCfg_s       refPwr,
  input wire bleedCfg_s        bleed,
  input wire logic [2:0]       abpWidthCode,
  input wire logic [2:0]       rfDividerSel,
  input wire logic             cpHighZ,
  input wire logic             countersHeld,
  input wire logic             lockDetectClear,
  input wire logic             rfBuffersOff,
  input wire logic             integerLoad,
  input wire logic             pfdRefPulse
);
  // one domain, so one clock and one disable for all
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // derived controls lag the stored word by one cycle
  a_cp_highz: assert property (
    cpHighZ == $past(refPwr.cpTristate | refPwr.powerDown))
    else $error("pump three-state wrong");
  a_counters_held: assert property (
    countersHeld == $past(refPwr.counterReset | refPwr.powerDown))
    else $error("counter hold wrong");
  a_pd_outputs: assert property (
    lockDetectClear == $past(refPwr.powerDown)
    && rfBuffersOff == lockDetectClear)
    else $error("power-down outputs wrong");
  a_abp_code: assert property (
    abpWidthCode == ($past(bleed.abpNarrow) ? ABP_NARROW_CODE
                     : {1'b0, $past(bleed.bleedDelay)}))
    else $error("antibacklash code wrong");

  ////////////////////////////////////////////////////////////////////////////
  // shadowed values move only with the integer word
  a_load_pulse: assert property (
    integerLoad |=> !integerLoad)
    else $error("integer load longer than one cycle");
  a_mod_shadow: assert property (
    $changed(auxModulus) |-> integerLoad)
    else $error("modulus moved without integer word");
  a_rfdiv_shadow: assert property (
    $changed(rfDividerSel) && refPwr.dbufEn && $past(refPwr.dbufEn)
    |-> integerLoad)
    else $error("divider moved without integer word");

  ////////////////////////////////////////////////////////////////////////////
  // reference path pulses
  a_held_quiet: assert property (
    countersHeld [*3] |-> !pfdRefPulse)
    else $error("reference pulse while counters held");
  a_ref_single: assert property (
    pfdRefPulse |=> !pfdRefPulse)
    else $error("reference pulse too long");

  c_int_load: cover property (integerLoad);
  c_pd: cover property (rfBuffersOff && cpHighZ);
  c_narrow: cover property (abpWidthCode == ABP_NARROW_CODE);
  c_halved: cover property (pfdRefPulse && refPwr.halvingEn);
endmodule

// ### tb/serial_host_model.sv
// behavioural host shifting words into the serial programming port
`timescale 1ns/10ps
module serial_host_model
(
  input  wire logic       clk,
  input  wire logic [3:0] phase,  // clk cycles per pin phase, two or more
  output logic            serClk,
  output logic            serData,
  output logic            serLatch
);
  // pins idle low at start
  initial
  begin
    serClk = 1'b0;
    serData = 1'b0;
    serLatch = 1'b0;
  end

  // one pin phase, always ended on a falling clk edge
  task automatic hold_phase();
    repeat (phase) @(negedge clk);
  endtask

  // shift a whole word; caller enters on a falling edge
  task automatic send(input logic [31:0] w);
    int i;
    for (i = 31; i >= 0; i--)
    begin
      serData = w[i];
      hold_phase();
      serClk = 1'b1;
      hold_phase();
      serClk = 1'b0;
    end
    hold_phase();
    serLatch = 1'b1;
    hold_phase();
    serLatch = 1'b0;
    // stale data must not look valid
    serData = ~serData;
    hold_phase();
  endtask
endmodule

// ### tb/tb.sv
// self-checking bench for the pll configuration registers
`timescale 1ns/10ps
module tb
  import pll_cfg_pkg::*;
;
  logic             clk, rst_n, serClk, serData, serLatch, reference_input;
  logic [3:0]       phase;                  // host pin phase length
  logic [AUX_W-1:0] auxModulus, auxFraction;
  refPwrCfg_s       refPwr;
  bleedCfg_s        bleed;
  logic [2:0]       abpWidthCode, rfDividerSel, rfSh, rfLive;
  logic             cpHighZ, countersHeld, lockDetectClear, rfBuffersOff;
  logic             integerLoad, pfdRefPulse;
  logic [31:0]      rs, refW, bleedW, w;    // model words
  logic [13:0]      modSh, modLive, fracQ;  // model aux values
  int               n_mismatch, total_checks, nLoad, nInt, nPulse, i, k;
  // divider table: ratio, doubler, halving, hold; and pulse counts
  logic [31:0]      cfgW [5] = '{32'h00008004, 32'h02018004,
                                 32'h04010004, 32'h06018004, 32'h00008014};
  logic [31:0]      expP [5] = '{24, 4, 24, 8, 0};

  pll_config_regs u_pll_config_regs (.clk(clk), .rst_n(rst_n),
    .serClk(serClk), .serData(serData), .serLatch(serLatch), .reference_input(reference_input),
    .auxModulus(auxModulus), .auxFraction(auxFraction), .refPwr(refPwr),
    .bleed(bleed), .abpWidthCode(abpWidthCode),
    .rfDividerSel(rfDividerSel), .cpHighZ(cpHighZ),
    .countersHeld(countersHeld), .lockDetectClear(lockDetectClear),
    .rfBuffersOff(rfBuffersOff), .integerLoad(integerLoad),
    .pfdRefPulse(pfdRefPulse));
  serial_host_model u_serial_host_model (.clk(clk), .phase(phase),
    .serClk(serClk), .serData(serData), .serLatch(serLatch));

  ////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // count one-cycle pulses of the design
  always @(posedge clk)
  begin
    if (integerLoad === 1'b1) nLoad++;
    if (pfdRefPulse === 1'b1) nPulse++;
  end

  // xorshift source
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // every output except pfdRefPulse against the model
  task automatic check_all();
    chk(32'(auxModulus), 32'(modLive));
    chk(32'(auxFraction), 32'(fracQ));
    chk(32'(refPwr), {6'h0, refW[30:10], refW[8:4]});
    chk(32'(bleed), {28'h0, bleedW[25], bleedW[27:26], bleedW[23]});
    chk(32'(abpWidthCode), bleedW[23] ? 32'h4 : 32'(bleedW[27:26]));
    chk(32'(rfDividerSel), 32'(rfLive));
    chk({28'h0, cpHighZ, countersHeld, lockDetectClear, rfBuffersOff},
        {28'h0, refW[5] | refW[6], refW[4] | refW[6], refW[6], refW[6]});
    chk(32'(nLoad), 32'(nInt));
  endtask

  // model update, host transfer, then full compare
  task automatic wr(input logic [31:0] wd);
    case (wd[3:0])
      CTRL_INTEGER:
      begin
        modLive = modSh;
        nInt++;
        if (refW[DBUF_BIT]) rfLive = rfSh;
      end
      CTRL_AUX_MOD: modSh = wd[17:4];
      CTRL_AUX_FRAC: fracQ = wd[17:4];
      CTRL_REF_PWR: refW = wd;
      CTRL_BLEED: bleedW = wd;
      CTRL_REG_SIX:
      begin
        rfSh = wd[23:21];
        if (!refW[DBUF_BIT]) rfLive = wd[23:21];
      end
      default: ;
    endcase
    u_serial_host_model.send(wd);
    check_all();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // hang guard
  initial
  begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    test_done();
  end

  initial
  begin
    {rst_n, rfSh, rfLive, modSh, modLive, fracQ, bleedW} = '0;
    {n_mismatch, total_checks, nLoad, nInt, nPulse} = '0;
    rs = 32'h2c26;
    phase = 4'h2;
    reference_input = 1'b1;
    refW = 32'h00008000;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check_all();
    // shadowed modulus, prompt and slow host
    for (i = 0; i < 3; i++)
    begin
      w = rnd();
      phase = 4'(2 + i);
      wr({14'h0, w[13:0] | 14'h1, CTRL_AUX_MOD});
      wr({14'h0, 14'(w[31:18] % (w[13:0] | 14'h1)), CTRL_AUX_FRAC});
      wr({11'h0, w[20], w[31:16], CTRL_INTEGER});
    end
    phase = 4'h2;
    for (i = 0; i < 6; i++)
    begin
      // reserved zero, power-down clear, ratio nonzero
      wr((rnd() & 32'h7fffbdb0) | 32'h8004 | (32'(i % 2) << DBUF_BIT));
      wr((rnd() & 32'h0e800000) | 32'(CTRL_BLEED));
      wr((rnd() & 32'h00e00000) | 32'(CTRL_REG_SIX));
      wr(32'h00000640);
    end
    for (k = 6; k < 16; k++)
      wr((rnd() & 32'h0ffffff0) | 32'((k == 6) ? 1 : k));
    wr(32'h001ffff0);
    wr(refW | 32'h40);
    // writes still taken while powered down
    wr({14'h0, 14'h0155, CTRL_AUX_MOD});
    wr({14'h0, 14'h00aa, CTRL_AUX_FRAC});
    wr(32'h00000640);
    wr(refW & ~32'h40);
    for (i = 0; i < 5; i++)
    begin
      wr(cfgW[i]);
      nPulse = 0;
      repeat (24)
      begin
        reference_input = 1'b0;
        repeat (5) @(negedge clk);
        reference_input = 1'b1;
        repeat (5) @(negedge clk);
      end
      chk(32'(nPulse), expP[i]);
    end
    test_done();
  end
endmodule

bind pll_config_regs pll_config_regs_asserts u_pll_config_regs_asserts (
  .clk(clk), .rst_n(rst_n), .serClk(serClk), .serData(serData),
  .serLatch(serLatch), .reference_input(reference_input), .auxModulus(auxModulus),
  .auxFraction(auxFraction), .refPwr(refPwr), .bleed(bleed),
  .abpWidthCode(abpWidthCode), .rfDividerSel(rfDividerSel),
  .cpHighZ(cpHighZ), .countersHeld(countersHeld),
  .lockDetectClear(lockDetectClear), .rfBuffersOff(rfBuffersOff),
  .integerLoad(integerLoad), .pfdRefPulse(pfdRefPulse));
